// ---- bench/pqb_src_model.sv ----
// Upstream element model feeding both block inputs
`timescale 1ns/1ps
module pqb_src_model (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_slow,
  input  wire logic [1:0]        i_ready,
  output logic      [1:0]        o_valid,
  output pqb_pkg::pqb_pkt_s [1:0] o_pkt
);
  pqb_pkg::pqb_pkt_s q [2][$];
  initial begin
    o_valid = 2'b00;
    o_pkt   = '0;
  end
  // Bench hands descriptors in; they leave in the order given
  task automatic push(input int lane, input pqb_pkg::pqb_pkt_s p);
    q[lane].push_back(p);
  endtask
  // Hold each descriptor until ready is seen; slow mode leaves a gap after each transfer
  always @(posedge i_mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (!i_rst && o_valid[i] && i_ready[i]) void'(q[i].pop_front());
      if (!i_rst && q[i].size() > 0 && !(i_slow && o_valid[i] && i_ready[i])) begin
        o_valid[i] <= 1'b1;
        o_pkt[i]   <= q[i][0];
      end else begin
        o_valid[i] <= 1'b0;
        o_pkt[i]   <= ~o_pkt[i]; // Idle lines invert the data each cycle instead of holding a stale packet
      end
    end
  end
endmodule // pqb_src_model

// ---- bench/pqb_top_assertions.sv ----
// Concurrent checks on the queueing block ports
`timescale 1ns/1ps
module pqb_top_assertions #(
  parameter int POOL = 48
) (
  input wire logic              i_mclk,
  input wire logic              i_rst,
  input wire logic              i_rd,
  input wire logic [31:0]       o_rdata,
  input wire logic [1:0]        i_in_valid,
  input wire logic [1:0]        o_in_ready,
  input wire logic              o_out_valid,
  input wire pqb_pkg::pqb_pkt_s o_out_pkt,
  input wire logic              o_out_src,
  input wire logic              i_out_ready,
  input wire logic [1:0]        o_drop_tail,
  input wire logic [1:0]        o_drop_head
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Packets held per input
  // ----------------------------------------
  // Over-counts a dropped arrival for one cycle, so bounds below keep slack
  logic [7:0] occ_reg [2];
  always_ff @(posedge i_mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (i_rst) occ_reg[i] <= 8'h00;
      else occ_reg[i] <= occ_reg[i] + 8'(i_in_valid[i] && o_in_ready[i]) - 8'(o_drop_tail[i])
                         - 8'(o_drop_head[i]) - 8'(o_out_valid && i_out_ready && (o_out_src == 1'(i)));
    end
  end
  rdata_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its slot");
  out_hold_a: assert property (o_out_valid && !i_out_ready |=>
    o_out_valid && $stable(o_out_pkt) && $stable(o_out_src)) else $error("output changed before taken");
  tail_cause0_a: assert property (o_drop_tail[0] |-> $past(i_in_valid[0] && o_in_ready[0]))
    else $error("tail drop without arrival on input 0");
  tail_cause1_a: assert property (o_drop_tail[1] |-> $past(i_in_valid[1] && o_in_ready[1]))
    else $error("tail drop without arrival on input 1");
  out_origin_a: assert property (o_out_valid |-> occ_reg[o_out_src] != 8'h00)
    else $error("output packet never accepted");
  head_cause_a: assert property (o_drop_head[0] |-> occ_reg[0] != 8'h00)
    else $error("head drop from empty queue");
  pool_bound_a: assert property (32'(occ_reg[0]) + 32'(occ_reg[1]) <= POOL + 3)
    else $error("more packets held than buffers");
  ready_rise_a: assert property ($fell(i_rst) |=> o_in_ready == 2'b11)
    else $error("inputs not ready after reset");
  reset_idle_a: assert property ($fell(i_rst) |-> !o_out_valid && o_drop_tail == 2'b00)
    else $error("activity right after reset");
  cov_deliver: cover property (o_out_valid && i_out_ready);
  cov_stall: cover property (o_out_valid && !i_out_ready ##1 o_out_valid && i_out_ready);
  cov_tail: cover property (|o_drop_tail);
  cov_head: cover property (o_drop_head[0]);
endmodule // pqb_top_assertions

// ---- bench/testbench.sv ----
// Self-checking bench for the queueing block
`timescale 1ns/1ps
module testbench;
  localparam int POOL = 48;
  localparam logic [7:0] RA [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h30};
  localparam logic [31:0] RV [11] = '{32'h7, 32'hFFFFFF, 32'hFFFFFF, 32'h64, 32'h0, 32'h0FFFF08, 32'h0FFFF08,
                                      32'(POOL) << 16, 32'h0, 32'h0, 32'h0};
  logic                    i_mclk = 1'b0;
  logic                    i_rst = 1'b1;
  logic [7:0]              i_addr = 8'h00;
  logic [31:0]             i_wdata = 32'h0;
  logic                    i_wr = 1'b0;
  logic                    i_rd = 1'b0;
  logic                    i_out_ready = 1'b1;
  logic                    stall = 1'b0;
  logic                    slow = 1'b0;
  logic [31:0]             o_rdata;
  logic [1:0]              in_valid, in_ready, drop_tail, drop_head;
  pqb_pkg::pqb_pkt_s [1:0] in_pkt;
  logic                    o_out_valid, o_out_src;
  pqb_pkg::pqb_pkt_s       o_out_pkt;
  pqb_pkg::pqb_pkt_s       got [2][$];
  int                      n_errors = 0;
  int                      total_checks = 0;
  int                      tails = 0;
  int                      heads = 0;
  always #10 i_mclk = ~i_mclk;
  pqb_top #(.DEPTH(32), .POOL(POOL)) DUT (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_in_valid(in_valid), .i_in_pkt(in_pkt), .o_in_ready(in_ready),
    .o_out_valid(o_out_valid), .o_out_pkt(o_out_pkt), .o_out_src(o_out_src), .i_out_ready(i_out_ready),
    .o_drop_tail(drop_tail), .o_drop_head(drop_head));
  pqb_src_model src (.i_mclk(i_mclk), .i_rst(i_rst), .i_slow(slow), .i_ready(in_ready), .o_valid(in_valid),
    .o_pkt(in_pkt));
  // Collect departures and drop pulses; stall mode toggles downstream ready
  always @(posedge i_mclk) begin
    if (!i_rst) begin
      if (o_out_valid && i_out_ready) got[o_out_src].push_back(o_out_pkt);
      tails += drop_tail[0] + drop_tail[1];
      heads += drop_head[0] + drop_head[1];
    end
    if (stall) i_out_ready <= ~i_out_ready;
  end
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1 check(o_rdata, exp, "register read");
  endtask
  function automatic pqb_pkg::pqb_pkt_s pk(input logic [5:0] cp);
    return '{dscp: cp, len: 10'h040};
  endfunction
  // Wait for n departures on a lane, code points counting up from cp0
  task automatic drain(input int lane, input logic [5:0] cp0, input int n);
    int w;
    w = 0;
    while (got[lane].size() < n && w < 400) begin
      @(posedge i_mclk);
      w++;
    end
    check(32'(got[lane].size()), 32'(n), "departures");
    for (int k = 0; k < got[lane].size(); k++) check(32'(got[lane][k]), 32'(pk(cp0 + 6'(k))), "order");
    got[lane].delete();
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog: about 5000 cycles, several times the planned run
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    foreach (RA[k]) rd(RA[k], RV[k]);
    wr(8'h1C, 32'hFFFFFFFF);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h1C, 32'(POOL) << 16);
    rd(8'h30, 32'h0);
    $display("test reset values done");
    // Hold both queues with zero rates, then release work conserving under stalls
    wr(8'h00, 32'h6);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0);
    for (int k = 1; k <= 3; k++) src.push(0, pk(6'(k)));
    src.push(1, pk(6'h21));
    src.push(1, pk(6'h22));
    repeat (40) @(posedge i_mclk);
    check(32'(got[0].size() + got[1].size()), 32'h0, "held");
    rd(8'h1C, {8'h00, 8'(POOL - 5), 8'h02, 8'h03});
    stall <= 1'b1;
    wr(8'h00, 32'h7);
    drain(0, 6'h01, 3);
    drain(1, 6'h21, 2);
    stall <= 1'b0;
    @(posedge i_mclk);
    i_out_ready <= 1'b1;
    $display("test order done");
    // Shaping: 64 octets at 8 per tick may not leave for 128 cycles
    wr(8'h00, 32'h6);
    wr(8'h14, 32'h00040800);
    src.push(0, pk(6'h07));
    repeat (60) @(posedge i_mclk);
    check(32'(got[0].size()), 32'h0, "shaped early");
    drain(0, 6'h07, 1);
    wr(8'h14, 32'h0);
    $display("test shaping done");
    // Tail drop at a packet threshold of 2, slow upstream
    slow <= 1'b1;
    wr(8'h04, 32'h00FFFF02);
    wr(8'h08, 32'h00FFFF02);
    for (int k = 0; k < 4; k++) begin
      src.push(0, pk(k < 2 ? 6'h09 : 6'h05));
      src.push(1, pk(6'h0A + 6'(k)));
    end
    repeat (30) @(posedge i_mclk);
    check(32'(tails), 32'h4, "tail drops");
    rd(8'h20, 32'h4);
    rd(8'h1C, {8'h00, 8'(POOL - 4), 8'h02, 8'h02});
    $display("test tail drop done");
    // Head discard of one code point: AND trigger stays false, OR trigger fires
    wr(8'h04, 32'hFFFFFF);
    wr(8'h08, 32'hFFFFFF);
    src.push(0, pk(6'h05));
    wr(8'h00, 32'hE);
    wr(8'h0C, 32'h1);
    wr(8'h10, 32'h49);
    repeat (20) @(posedge i_mclk);
    check(32'(heads), 32'h0, "and trigger");
    wr(8'h00, 32'h6);
    repeat (20) @(posedge i_mclk);
    check(32'(heads), 32'h2, "head drops");
    rd(8'h20, 32'h00020004);
    wr(8'h10, 32'h0);
    wr(8'h0C, 32'h64);
    wr(8'h00, 32'h7);
    drain(0, 6'h05, 1);
    drain(1, 6'h0A, 2);
    $display("test head discard done");
    stop_test();
  end
endmodule // testbench
bind pqb_top pqb_top_assertions #(.POOL(POOL)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_rd(i_rd), .o_rdata(o_rdata), .i_in_valid(i_in_valid),
  .o_in_ready(o_in_ready), .o_out_valid(o_out_valid), .o_out_pkt(o_out_pkt), .o_out_src(o_out_src),
  .i_out_ready(i_out_ready), .o_drop_tail(o_drop_tail), .o_drop_head(o_drop_head));

// ---- src/pqb_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the queueing block
`ifndef PQB_CFG_SVH
`define PQB_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PQB_CTRL   8'h00
`define PQB_QTHR0  8'h04
`define PQB_QTHR1  8'h08
`define PQB_TRIG   8'h0C
`define PQB_KILLCP 8'h10
`define PQB_SCHED0 8'h14
`define PQB_SCHED1 8'h18
`define PQB_STAT   8'h1C
`define PQB_DROPS  8'h20
`define PQB_OCTS   8'h24
// ----------------------------------------
// Control fields
// ----------------------------------------
`define PQB_C_WC   0
`define PQB_C_TAIL 1
`define PQB_C_HEAD 2
`define PQB_C_AND  3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PQB_CTRL_RST   4'h7
`define PQB_QTHR_RST   24'hFFFFFF
`define PQB_TRIG_RST   16'h0064
`define PQB_KILLCP_RST 15'h0000
`define PQB_SCHED_RST  27'h0FFFF08
// ----------------------------------------
// Timing: token refill period
// ----------------------------------------
`define PQB_CLK_NS   20
`define PQB_TICK_NS  320
`define PQB_TICK_CYC (`PQB_TICK_NS / `PQB_CLK_NS)
`endif

// ---- src/pqb_fifo.sv ----
// Ordered packet store with depth tracking and in-place discard marking
`timescale 1ns/1ps
module pqb_fifo #(
  parameter int DEPTH = 32
) (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  pqb_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  pqb_pkg::pqb_pkt_s mem_reg [DEPTH];
  logic [DEPTH-1:0]  kill_reg;
  logic [AW-1:0]     rd_reg;
  logic [AW-1:0]     wr_reg;
  logic [7:0]        cnt_reg;
  logic [15:0]       oct_reg;
  logic              pop;
  logic [7:0]        cnt_next;

  // Code point match against the two enabled out-of-profile values
  function automatic logic hit(input logic [5:0] d, input logic [13:0] cp);
    hit = (cp[6] && d == cp[5:0]) || (cp[13] && d == cp[12:7]);
  endfunction

  // Marked heads leave on their own so order is never disturbed
  assign f.head_drop  = (cnt_reg != 8'h00) && kill_reg[rd_reg];
  assign pop          = f.head_drop || f.deq;
  assign f.head_valid = (cnt_reg != 8'h00) && !kill_reg[rd_reg];
  assign f.head_pkt   = mem_reg[rd_reg];
  assign cnt_next     = cnt_reg + {7'h00, f.enq} - {7'h00, pop};
  assign f.depth      = cnt_reg;
  assign f.octets     = oct_reg;
  assign f.full       = cnt_reg == 8'(DEPTH);
  assign f.full_next  = cnt_next == 8'(DEPTH);

  // Storage and marking; marking only flags, entries never move
  always_ff @(posedge i_mclk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (f.kill_req && hit(mem_reg[i].dscp, f.kill_cp)) begin
        kill_reg[i] <= 1'b1;
      end
    end
    if (f.enq) begin
      mem_reg[wr_reg]  <= f.enq_pkt;
      kill_reg[wr_reg] <= 1'b0;
    end
    if (i_rst) begin
      kill_reg <= '0;
    end
  end

  // Pointers and counts
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rd_reg  <= '0;
      wr_reg  <= '0;
      cnt_reg <= 8'h00;
      oct_reg <= 16'h0000;
    end else begin
      if (f.enq) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop) rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_next;
      oct_reg <= oct_reg + (f.enq ? {6'h00, f.enq_pkt.len} : 16'h0000)
                         - (pop ? {6'h00, f.head_pkt.len} : 16'h0000);
    end
  end
endmodule // pqb_fifo

// ---- src/pqb_fifo_if.sv ----
// Link between the queue controller and one packet store
`timescale 1ns/1ps
interface pqb_fifo_if;
  logic              enq;
  pqb_pkg::pqb_pkt_s enq_pkt;
  logic              deq;
  logic              head_valid;
  pqb_pkg::pqb_pkt_s head_pkt;
  logic [7:0]        depth;
  logic [15:0]       octets;
  logic              full;
  logic              full_next;
  logic              kill_req;
  logic [13:0]       kill_cp;
  logic              head_drop;
  modport ctl (output enq, enq_pkt, deq, kill_req, kill_cp,
               input head_valid, head_pkt, depth, octets, full, full_next, head_drop);
  modport store (input enq, enq_pkt, deq, kill_req, kill_cp,
                 output head_valid, head_pkt, depth, octets, full, full_next, head_drop);
endinterface

// ---- src/pqb_pkg.sv ----
// Types shared by the queueing block modules
package pqb_pkg;
  // Packet descriptor: code point and length in octets
  typedef struct packed {
    logic [5:0] dscp;
    logic [9:0] len;
  } pqb_pkt_s;
  // Why the scheduler granted an input
  typedef enum logic [1:0] {
    GR_NONE,
    GR_MIN,
    GR_EXCESS
  } pqb_grant_e;
endpackage

// ---- src/pqb_top.sv ----
// Queueing block: two packet queues, tail and head discarders, rate scheduler
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "pqb_cfg.svh"
module pqb_top #(
  parameter int DEPTH = 32,
  parameter int POOL  = 48
) (
  input  wire logic                           i_mclk,
  input  wire logic                           i_rst,
  input  wire logic [7:0]                     i_addr,
  input  wire logic [31:0]                    i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [31:0]                    o_rdata,
  input  wire logic [1:0]                     i_in_valid,
  input  wire pqb_pkg::pqb_pkt_s [1:0]        i_in_pkt,
  output logic      [1:0]                     o_in_ready,
  output logic                                o_out_valid,
  output pqb_pkg::pqb_pkt_s                   o_out_pkt,
  output logic                                o_out_src,
  input  wire logic                           i_out_ready,
  output logic      [1:0]                     o_drop_tail,
  output logic      [1:0]                     o_drop_head
);
  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [3:0]  ctrl_reg;
  logic [23:0] qthr_reg [2];
  logic [15:0] trig_reg;
  logic [14:0] killcp_reg;
  logic [26:0] sched_reg [2];
  logic [15:0] tdrops_reg;
  logic [15:0] hdrops_reg;
  logic [31:0] rdata_reg;

  // ----------------------------------------
  // Datapath state
  // ----------------------------------------
  logic [1:0]        ready_reg;
  logic              ov_reg;
  pqb_pkg::pqb_pkt_s opkt_reg;
  logic              osrc_reg;
  logic [1:0]        dtail_reg;
  logic [1:0]        dhead_reg;
  logic              rr_reg;
  logic [15:0]       mintok_reg [2];
  logic [15:0]       maxtok_reg [2];
  logic [7:0]        tick_reg;

  // ----------------------------------------
  // Shared wires
  // ----------------------------------------
  pqb_fifo_if q [2] ();
  logic              wc;
  logic              tail_en;
  logic              head_en;
  logic [7:0]        pool_free;
  logic              pool_low;
  logic              tick;
  logic              slot;
  logic [1:0]        acc;
  logic [1:0]        tdrop;
  logic [1:0]        over;
  logic [1:0]        fire;
  logic [1:0]        maxok;
  logic [1:0]        el_min;
  logic [1:0]        el_ex;
  pqb_pkg::pqb_grant_e why;
  logic              gsel;
  logic [1:0]        send;
  logic [31:0]       rd_val;
  logic [1:0]        ntd;
  logic [1:0]        nhd;
  pqb_pkg::pqb_pkt_s hpkt [2];

  // Pick between two inputs, preferring the one after the last grant
  function automatic logic pick2(input logic [1:0] e, input logic last);
    pick2 = e[~last] ? ~last : last;
  endfunction

  // Saturating token refill and charge
  function automatic logic [15:0] tok_upd(input logic [15:0] t, input logic add,
                                          input logic [7:0] rate, input logic [7:0] burst,
                                          input logic sub, input logic [9:0] len);
    logic [16:0] v;
    logic [16:0] cap;
    v   = {1'b0, t};
    cap = {5'h00, burst, 4'h0};
    if (add) v = v + {9'h000, rate};
    if (v > cap) v = cap;
    if (sub) v = (v > {7'h00, len}) ? v - {7'h00, len} : 17'h00000;
    tok_upd = v[15:0];
  endfunction

  // ----------------------------------------
  // Packet stores
  // ----------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_q
    pqb_fifo #(
      .DEPTH (DEPTH)
    ) u_fifo (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .f      (q[i])
    );
  end

  // Decoded control fields
  assign wc      = ctrl_reg[`PQB_C_WC];
  assign tail_en = ctrl_reg[`PQB_C_TAIL];
  assign head_en = ctrl_reg[`PQB_C_HEAD];

  // Shared buffer pool, level derived from what both queues hold
  assign pool_free = 8'(POOL) - q[0].depth - q[1].depth;
  assign pool_low  = pool_free < trig_reg[15:8];

  // Refill strobe for every token bucket
  assign tick = tick_reg == 8'(`PQB_TICK_CYC - 1);

  // Output slot is open when empty or being drained this cycle
  assign slot = !ov_reg || i_out_ready;

  // ----------------------------------------
  // Per-input discard and eligibility
  // ----------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_in
    // Arrival-triggered drop-on-threshold ahead of the tail
    assign acc[i]   = i_in_valid[i] && ready_reg[i];
    assign tdrop[i] = tail_en && (q[i].full || pool_free == 8'h00
                    || q[i].depth >= qthr_reg[i][7:0]
                    || q[i].octets + {6'h00, i_in_pkt[i].len}
                       > qthr_reg[i][23:8]);
    assign q[i].enq     = acc[i] && !tdrop[i];
    assign q[i].enq_pkt = i_in_pkt[i];

    // Queue-depth and pool-level trigger acting on the queue head
    assign over[i] = q[i].depth > trig_reg[7:0];
    assign fire[i] = ctrl_reg[`PQB_C_AND] ? (over[i] && pool_low)
                                          : (over[i] || pool_low);
    assign q[i].kill_req = head_en && fire[i];
    assign q[i].kill_cp  = killcp_reg[13:0];

    // Shaping: the maximum-rate bucket must hold the whole packet
    assign maxok[i]  = wc || maxtok_reg[i] >= {6'h00, q[i].head_pkt.len};
    assign el_min[i] = q[i].head_valid && maxok[i]
                     && mintok_reg[i] >= {6'h00, q[i].head_pkt.len};
    assign el_ex[i]  = q[i].head_valid && maxok[i];
    assign send[i]   = slot && why != pqb_pkg::GR_NONE && gsel == 1'(i);
    assign q[i].deq  = send[i];
    assign ntd[i]    = acc[i] && tdrop[i];
    assign nhd[i]    = q[i].head_drop;
    assign hpkt[i]   = q[i].head_pkt;  // Plain copy, so heads can be picked by a run-time index
  end

  // ----------------------------------------
  // Grant selection
  // ----------------------------------------
  // Minimum rates are served first, round-robin among them; what is left goes by priority
  always_comb begin
    why  = pqb_pkg::GR_NONE;
    gsel = 1'b0;
    if (el_min != 2'b00) begin
      why  = pqb_pkg::GR_MIN;
      gsel = pick2(el_min, rr_reg);
    end else if (el_ex != 2'b00) begin
      why = pqb_pkg::GR_EXCESS;
      if (el_ex != 2'b11) begin
        gsel = el_ex[1];
      end else if (sched_reg[0][26:24] != sched_reg[1][26:24]) begin
        gsel = sched_reg[1][26:24] < sched_reg[0][26:24];
      end else begin
        gsel = pick2(el_ex, rr_reg);
      end
    end
  end

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  // Unmapped offsets read as zero
  always_comb begin
    case (i_addr)
      `PQB_CTRL:   rd_val = {28'h0000000, ctrl_reg};
      `PQB_QTHR0:  rd_val = {8'h00, qthr_reg[0]};
      `PQB_QTHR1:  rd_val = {8'h00, qthr_reg[1]};
      `PQB_TRIG:   rd_val = {16'h0000, trig_reg};
      `PQB_KILLCP: rd_val = {17'h00000, killcp_reg};
      `PQB_SCHED0: rd_val = {5'h00, sched_reg[0]};
      `PQB_SCHED1: rd_val = {5'h00, sched_reg[1]};
      `PQB_STAT:   rd_val = {8'h00, pool_free, q[1].depth, q[0].depth};
      `PQB_DROPS:  rd_val = {hdrops_reg, tdrops_reg};
      `PQB_OCTS:   rd_val = {q[1].octets, q[0].octets};
      default:     rd_val = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Configuration only; depths are never writable
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_reg     <= `PQB_CTRL_RST;
      qthr_reg[0]  <= `PQB_QTHR_RST;
      qthr_reg[1]  <= `PQB_QTHR_RST;
      trig_reg     <= `PQB_TRIG_RST;
      killcp_reg   <= `PQB_KILLCP_RST;
      sched_reg[0] <= `PQB_SCHED_RST;
      sched_reg[1] <= `PQB_SCHED_RST;
    end else if (i_wr) begin
      case (i_addr)
        `PQB_CTRL:   ctrl_reg     <= i_wdata[3:0];
        `PQB_QTHR0:  qthr_reg[0]  <= i_wdata[23:0];
        `PQB_QTHR1:  qthr_reg[1]  <= i_wdata[23:0];
        `PQB_TRIG:   trig_reg     <= i_wdata[15:0];
        `PQB_KILLCP: killcp_reg   <= i_wdata[14:0];
        `PQB_SCHED0: sched_reg[0] <= i_wdata[26:0];
        `PQB_SCHED1: sched_reg[1] <= i_wdata[26:0];
        default: ;
      endcase
    end
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= i_rd ? rd_val : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Drop accounting
  // ----------------------------------------
  // Counters wrap; software takes differences
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tdrops_reg <= 16'h0000;
      hdrops_reg <= 16'h0000;
      dtail_reg  <= 2'b00;
      dhead_reg  <= 2'b00;
    end else begin
      tdrops_reg <= tdrops_reg + {15'h0000, ntd[0]} + {15'h0000, ntd[1]};
      hdrops_reg <= hdrops_reg + {15'h0000, nhd[0]} + {15'h0000, nhd[1]};
      dtail_reg  <= ntd;
      dhead_reg  <= nhd;
    end
  end

  // ----------------------------------------
  // Input handshake
  // ----------------------------------------
  // Ready is registered, so it looks at next-cycle fullness; with tail
  // dropping on, arrivals are always taken and full queues drop them.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ready_reg <= 2'b00;
    end else begin
      ready_reg[0] <= tail_en || !q[0].full_next;
      ready_reg[1] <= tail_en || !q[1].full_next;
    end
  end

  // ----------------------------------------
  // Token buckets
  // ----------------------------------------
  // Buckets refill every tick and are charged by the length sent
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tick_reg <= 8'h00;
      for (int i = 0; i < 2; i++) begin
        mintok_reg[i] <= 16'h0000;
        maxtok_reg[i] <= 16'h0000;
      end
    end else begin
      tick_reg <= tick ? 8'h00 : tick_reg + 8'h01;
      for (int i = 0; i < 2; i++) begin
        mintok_reg[i] <= tok_upd(mintok_reg[i], tick, sched_reg[i][7:0],
                                 sched_reg[i][23:16], send[i],
                                 hpkt[i].len);
        maxtok_reg[i] <= tok_upd(maxtok_reg[i], tick, sched_reg[i][15:8],
                                 sched_reg[i][23:16], send[i],
                                 hpkt[i].len);
      end
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  // One packet register; it holds until the receiver takes it
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ov_reg   <= 1'b0;
      opkt_reg <= '0;
      osrc_reg <= 1'b0;
      rr_reg   <= 1'b0;
    end else if (slot) begin
      ov_reg <= why != pqb_pkg::GR_NONE;
      if (why != pqb_pkg::GR_NONE) begin
        opkt_reg <= hpkt[gsel];
        osrc_reg <= gsel;
        rr_reg   <= gsel;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_rdata     = rdata_reg;
  assign o_in_ready  = ready_reg;
  assign o_out_valid = ov_reg;
  assign o_out_pkt   = opkt_reg;
  assign o_out_src   = osrc_reg;
  assign o_drop_tail = dtail_reg;
  assign o_drop_head = dhead_reg;
endmodule // pqb_top
